// ==== core/aba_dev.sv ====
`timescale 1ns/100ps
`include "aba_cfg.svh"
module aba_dev #(
	parameter int DEPTH = 16,
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// link to host
	aba_if.dev LNK,
	// status
	output logic BUSY,
	output logic OP_DONE,
	output logic OP_CHANGED,
	output logic OP_ERR
);
	import aba_pkg::*;

	localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	//--------------------------------------------------
	// state
	//--------------------------------------------------
	aba_dev_state_e state_q;
	aba_dev_state_e state_d;
	aba_cmd_t cmd_q;
	aba_cmd_t cmd_d;
	aba_len_t len_q;
	aba_len_t len_d;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	aba_data_t pay_q;
	aba_data_t pay_d;
	logic req_ready_q;
	logic req_ready_d;
	logic rsp_valid_q;
	logic rsp_valid_d;
	aba_data_t rsp_data_q;
	aba_data_t rsp_data_d;
	logic rsp_flag_q;
	logic rsp_flag_d;
	logic rsp_err_q;
	logic rsp_err_d;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic done_d;
	logic chg_q;
	logic chg_d;
	logic err_q;
	logic err_d;

	//--------------------------------------------------
	// storage
	//--------------------------------------------------
	aba_data_t mem_q [DEPTH];
	aba_data_t mem_d [DEPTH];

	//--------------------------------------------------
	// operation result
	//--------------------------------------------------
	logic [IDX_W-1:0] idx;
	logic upper_sel;
	aba_data_t old_blk;
	aba_half_t old_half;
	aba_half_t bit_mask;
	aba_half_t bit_data;
	aba_half_t new_half;
	aba_data_t result;
	aba_data_t rsp_calc;
	logic flag_calc;
	logic err_calc;
	logic wr_en;

	assign idx = addr_q[`ABA_BLK_LSB +: IDX_W];
	assign upper_sel = addr_q[`ABA_HALF_SEL_BIT];
	assign old_blk = mem_q[idx];
	assign bit_mask = pay_q[`ABA_MASK_LSB +: `ABA_HALF_W];
	assign bit_data = pay_q[`ABA_WDATA_LSB +: `ABA_HALF_W];

	always_comb begin
		old_half = upper_sel ? old_blk[`ABA_MASK_LSB +: `ABA_HALF_W] :
			old_blk[`ABA_WDATA_LSB +: `ABA_HALF_W];
		new_half = (old_half & ~bit_mask) | (bit_data & bit_mask);
		result = old_blk;
		rsp_calc = `ABA_ZERO_DATA;
		flag_calc = 1'b0;
		err_calc = 1'b0;
		wr_en = 1'b0;
		if (len_q != `ABA_LEN_ATOMIC) begin
			err_calc = 1'b1;
		end else begin
			case (cmd_q)
				`ABA_CMD_MASKED_WRITE_RETURN: begin
					if (upper_sel) begin
						result[`ABA_MASK_LSB +: `ABA_HALF_W] = new_half;
					end else begin
						result[`ABA_WDATA_LSB +: `ABA_HALF_W] = new_half;
					end
					rsp_calc = {`ABA_ZERO_HALF, old_half};
					flag_calc = |(old_half ^ new_half);
					wr_en = 1'b1;
				end
				`ABA_CMD_EXCHANGE_SIXTEEN: begin
					result = pay_q;
					rsp_calc = old_blk;
					flag_calc = 1'b0;
					wr_en = 1'b1;
				end
				`ABA_CMD_AND_SIXTEEN: begin
					result = old_blk & pay_q;
					rsp_calc = old_blk;
					flag_calc = |(old_blk & ~pay_q);
					wr_en = 1'b1;
				end
				default: begin
					err_calc = 1'b1;
				end
			endcase
		end
	end

	//--------------------------------------------------
	// next state
	//--------------------------------------------------
	always_comb begin
		state_d = state_q;
		cmd_d = cmd_q;
		len_d = len_q;
		addr_d = addr_q;
		pay_d = pay_q;
		req_ready_d = req_ready_q;
		rsp_valid_d = rsp_valid_q;
		rsp_data_d = rsp_data_q;
		rsp_flag_d = rsp_flag_q;
		rsp_err_d = rsp_err_q;
		busy_d = busy_q;
		done_d = 1'b0;
		chg_d = chg_q;
		err_d = err_q;
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = mem_q[i];
		end
		case (state_q)
			ABA_D_IDLE: begin
				if (LNK.req_valid && req_ready_q) begin
					cmd_d = LNK.req_cmd;
					len_d = LNK.req_len;
					addr_d = LNK.req_addr;
					pay_d = LNK.req_payload;
					req_ready_d = 1'b0;
					busy_d = 1'b1;
					state_d = ABA_D_EXEC;
				end
			end
			ABA_D_EXEC: begin
				if (wr_en) begin
					mem_d[idx] = result;
				end
				rsp_data_d = rsp_calc;
				rsp_flag_d = flag_calc;
				rsp_err_d = err_calc;
				rsp_valid_d = 1'b1;
				chg_d = flag_calc;
				err_d = err_calc;
				state_d = ABA_D_RESP;
			end
			ABA_D_RESP: begin
				if (LNK.rsp_ready) begin
					rsp_valid_d = 1'b0;
					req_ready_d = 1'b1;
					busy_d = 1'b0;
					done_d = 1'b1;
					state_d = ABA_D_IDLE;
				end
			end
			default: begin
				state_d = ABA_D_IDLE;
				req_ready_d = 1'b1;
				rsp_valid_d = 1'b0;
				busy_d = 1'b0;
			end
		endcase
	end

	//--------------------------------------------------
	// registers
	//--------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q <= ABA_D_IDLE;
			cmd_q <= '0;
			len_q <= '0;
			addr_q <= '0;
			pay_q <= `ABA_ZERO_DATA;
			req_ready_q <= 1'b1;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= `ABA_ZERO_DATA;
			rsp_flag_q <= 1'b0;
			rsp_err_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			chg_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			len_q <= len_d;
			addr_q <= addr_d;
			pay_q <= pay_d;
			req_ready_q <= req_ready_d;
			rsp_valid_q <= rsp_valid_d;
			rsp_data_q <= rsp_data_d;
			rsp_flag_q <= rsp_flag_d;
			rsp_err_q <= rsp_err_d;
			busy_q <= busy_d;
			done_q <= done_d;
			chg_q <= chg_d;
			err_q <= err_d;
		end
	end

	// storage clears on reset so reads are defined
	always_ff @(posedge CLK) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (SRST) begin
				mem_q[i] <= `ABA_ZERO_DATA;
			end else begin
				mem_q[i] <= mem_d[i];
			end
		end
	end

	//--------------------------------------------------
	// outputs
	//--------------------------------------------------
	assign LNK.req_ready = req_ready_q;
	assign LNK.rsp_valid = rsp_valid_q;
	assign LNK.rsp_payload = rsp_data_q;
	assign LNK.atomic_result_flag = rsp_flag_q;
	assign LNK.rsp_err = rsp_err_q;
	assign BUSY = busy_q;
	assign OP_DONE = done_q;
	assign OP_CHANGED = chg_q;
	assign OP_ERR = err_q;
endmodule

// ==== pkg/aba_cfg.svh ====
`ifndef ABA_CFG_SVH
`define ABA_CFG_SVH

// command codes
`define ABA_CMD_W 7
`define ABA_CMD_MASKED_WRITE_RETURN 7'h51
`define ABA_CMD_EXCHANGE_SIXTEEN 7'h6A
`define ABA_CMD_AND_SIXTEEN 7'h43

// packet length in flow units
`define ABA_LEN_W 4
`define ABA_LEN_ATOMIC 4'h2

// payload and operand layout
`define ABA_DATA_W 128
`define ABA_HALF_W 64
`define ABA_MASK_LSB 64
`define ABA_WDATA_LSB 0
`define ABA_HALF_SEL_BIT 3
`define ABA_BLK_LSB 4

// reset values
`define ABA_ZERO_HALF 64'h0000_0000_0000_0000
`define ABA_ZERO_DATA 128'h0000_0000_0000_0000_0000_0000_0000_0000

`endif

// ==== pkg/aba_pkg.sv ====
package aba_pkg;
	`include "aba_cfg.svh"

	typedef logic [`ABA_CMD_W-1:0] aba_cmd_t;
	typedef logic [`ABA_LEN_W-1:0] aba_len_t;
	typedef logic [`ABA_DATA_W-1:0] aba_data_t;
	typedef logic [`ABA_HALF_W-1:0] aba_half_t;

	typedef enum logic [1:0] {
		ABA_D_IDLE,
		ABA_D_EXEC,
		ABA_D_RESP
	} aba_dev_state_e;

	typedef enum logic [1:0] {
		ABA_H_IDLE,
		ABA_H_REQ,
		ABA_H_WAIT
	} aba_host_state_e;

	typedef enum logic [1:0] {
		ABA_OP_MASKED_WRITE,
		ABA_OP_EXCHANGE,
		ABA_OP_AND,
		ABA_OP_RAW
	} aba_op_e;
endpackage

// ==== pkg/aba_if.sv ====
`timescale 1ns/100ps
interface aba_if #(
	parameter int ADDR_W = 16
);
	import aba_pkg::*;

	// request channel
	logic req_valid;
	logic req_ready;
	aba_cmd_t req_cmd;
	aba_len_t req_len;
	logic [ADDR_W-1:0] req_addr;
	aba_data_t req_payload;

	// response channel
	logic rsp_valid;
	logic rsp_ready;
	aba_data_t rsp_payload;
	logic atomic_result_flag;
	logic rsp_err;

	modport dev (
		input req_valid, req_cmd, req_len, req_addr, req_payload, rsp_ready,
		output req_ready, rsp_valid, rsp_payload, atomic_result_flag, rsp_err
	);

	modport host (
		output req_valid, req_cmd, req_len, req_addr, req_payload, rsp_ready,
		input req_ready, rsp_valid, rsp_payload, atomic_result_flag, rsp_err
	);
endinterface

// ==== core/aba_host.sv ====
`timescale 1ns/100ps
`include "aba_cfg.svh"
module aba_host #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// link to device
	aba_if.host LNK,
	// user request
	input wire logic USR_START,
	input wire aba_pkg::aba_op_e USR_OP,
	input wire aba_pkg::aba_cmd_t USR_RAW_CMD,
	input wire logic [ADDR_W-1:0] USR_ADDR,
	input wire aba_pkg::aba_half_t USR_MASK,
	input wire aba_pkg::aba_half_t USR_WDATA,
	input wire aba_pkg::aba_data_t USR_IMM,
	// user answer
	output logic USR_BUSY,
	output logic USR_DONE,
	output aba_pkg::aba_data_t USR_RDATA,
	output logic USR_FLAG,
	output logic USR_ERR
);
	import aba_pkg::*;

	//--------------------------------------------------
	// state
	//--------------------------------------------------
	aba_host_state_e state_q;
	aba_host_state_e state_d;
	logic req_valid_q;
	logic req_valid_d;
	aba_cmd_t cmd_q;
	aba_cmd_t cmd_d;
	logic [ADDR_W-1:0] addr_q;
	logic [ADDR_W-1:0] addr_d;
	aba_data_t pay_q;
	aba_data_t pay_d;
	logic rsp_ready_q;
	logic rsp_ready_d;
	logic busy_q;
	logic busy_d;
	logic done_q;
	logic done_d;
	aba_data_t rdata_q;
	aba_data_t rdata_d;
	logic flag_q;
	logic flag_d;
	logic err_q;
	logic err_d;

	always_comb begin
		state_d = state_q;
		req_valid_d = req_valid_q;
		cmd_d = cmd_q;
		addr_d = addr_q;
		pay_d = pay_q;
		rsp_ready_d = rsp_ready_q;
		busy_d = busy_q;
		done_d = 1'b0;
		rdata_d = rdata_q;
		flag_d = flag_q;
		err_d = err_q;
		case (state_q)
			ABA_H_IDLE: begin
				if (USR_START) begin
					addr_d = USR_ADDR;
					case (USR_OP)
						ABA_OP_MASKED_WRITE: begin
							cmd_d = `ABA_CMD_MASKED_WRITE_RETURN;
							pay_d = {USR_MASK, USR_WDATA};
						end
						ABA_OP_EXCHANGE: begin
							cmd_d = `ABA_CMD_EXCHANGE_SIXTEEN;
							pay_d = USR_IMM;
						end
						ABA_OP_AND: begin
							cmd_d = `ABA_CMD_AND_SIXTEEN;
							pay_d = USR_IMM;
						end
						default: begin
							cmd_d = USR_RAW_CMD;
							pay_d = USR_IMM;
						end
					endcase
					req_valid_d = 1'b1;
					busy_d = 1'b1;
					state_d = ABA_H_REQ;
				end
			end
			ABA_H_REQ: begin
				if (LNK.req_ready) begin
					req_valid_d = 1'b0;
					rsp_ready_d = 1'b1;
					state_d = ABA_H_WAIT;
				end
			end
			ABA_H_WAIT: begin
				if (LNK.rsp_valid) begin
					rsp_ready_d = 1'b0;
					rdata_d = LNK.rsp_payload;
					flag_d = LNK.atomic_result_flag;
					err_d = LNK.rsp_err;
					busy_d = 1'b0;
					done_d = 1'b1;
					state_d = ABA_H_IDLE;
				end
			end
			default: begin
				state_d = ABA_H_IDLE;
				req_valid_d = 1'b0;
				rsp_ready_d = 1'b0;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_q <= ABA_H_IDLE;
			req_valid_q <= 1'b0;
			cmd_q <= '0;
			addr_q <= '0;
			pay_q <= `ABA_ZERO_DATA;
			rsp_ready_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rdata_q <= `ABA_ZERO_DATA;
			flag_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			state_q <= state_d;
			req_valid_q <= req_valid_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			pay_q <= pay_d;
			rsp_ready_q <= rsp_ready_d;
			busy_q <= busy_d;
			done_q <= done_d;
			rdata_q <= rdata_d;
			flag_q <= flag_d;
			err_q <= err_d;
		end
	end

	//--------------------------------------------------
	// outputs
	//--------------------------------------------------
	assign LNK.req_valid = req_valid_q;
	assign LNK.req_cmd = cmd_q;
	assign LNK.req_len = `ABA_LEN_ATOMIC;
	assign LNK.req_addr = addr_q;
	assign LNK.req_payload = pay_q;
	assign LNK.rsp_ready = rsp_ready_q;
	assign USR_BUSY = busy_q;
	assign USR_DONE = done_q;
	assign USR_RDATA = rdata_q;
	assign USR_FLAG = flag_q;
	assign USR_ERR = err_q;
endmodule

// ==== testbench/aba_props.sv ====
`timescale 1ns/100ps
`include "aba_cfg.svh"
module aba_props #(
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// request
	input wire logic req_valid,
	input wire logic req_ready,
	input wire aba_pkg::aba_cmd_t req_cmd,
	input wire aba_pkg::aba_len_t req_len,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire aba_pkg::aba_data_t req_payload,
	// response
	input wire logic rsp_valid,
	input wire logic rsp_ready,
	input wire aba_pkg::aba_data_t rsp_payload,
	input wire logic atomic_result_flag,
	input wire logic rsp_err
);
	import aba_pkg::*;
	// ---
	// link checks
	// ---
	logic tk;
	assign tk = req_valid && req_ready;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	len_two_a: assert property (req_valid |-> req_len == `ABA_LEN_ATOMIC)
		else $error("request length not two");
	ans_lat_a: assert property (tk |=> !rsp_valid ##1 rsp_valid)
		else $error("answer latency wrong");
	one_out_a: assert property (rsp_valid |-> !req_ready)
		else $error("request taken while answer pending");
	rdy_back_a: assert property (rsp_valid && rsp_ready |=> req_ready && !rsp_valid)
		else $error("link not idle after answer");
	xchg_flag_a: assert property (tk && req_cmd == `ABA_CMD_EXCHANGE_SIXTEEN |->
		##2 rsp_valid && !atomic_result_flag && !rsp_err) else $error("exchange flag set");
	mw_upper_a: assert property (tk && req_cmd == `ABA_CMD_MASKED_WRITE_RETURN |->
		##2 rsp_valid && rsp_payload[127:64] == `ABA_ZERO_HALF) else $error("upper bytes not zero");
	mw_flag_a: assert property (tk && req_cmd == `ABA_CMD_MASKED_WRITE_RETURN |-> ##2
		atomic_result_flag == |((rsp_payload[63:0] ^ $past(req_payload[63:0], 2)) & $past(req_payload[127:64], 2)))
		else $error("masked write flag wrong");
	and_flag_a: assert property (tk && req_cmd == `ABA_CMD_AND_SIXTEEN |-> ##2
		atomic_result_flag == |(rsp_payload & ~$past(req_payload, 2))) else $error("and flag wrong");
	err_zero_a: assert property (rsp_valid && rsp_err |->
		rsp_payload == `ABA_ZERO_DATA && !atomic_result_flag) else $error("refused answer not clean");
endmodule

// ==== testbench/tb_atomic_bitwrite_swap_and_unit.sv ====
`timescale 1ns/100ps
`include "aba_cfg.svh"
module tb_atomic_bitwrite_swap_and_unit;
	import aba_pkg::*;
	logic clk = 0, srst = 1, start = 0, busy, done, chg, err, h_busy, h_done, h_flag, h_err;
	aba_op_e op = ABA_OP_AND;
	aba_cmd_t raw = '0;
	logic [15:0] addr = '0;
	aba_half_t mask = '0, wd = '0;
	aba_data_t imm = '0, rdata;
	aba_data_t mem [16];
	int mismatches = 0, comparisons = 0, seed = 32'hc39f_51cf, i, n;
	always #50 clk = ~clk;
	aba_if lnk ();
	aba_dev aba_dev_inst (.CLK(clk), .SRST(srst), .LNK(lnk.dev), .BUSY(busy), .OP_DONE(done),
		.OP_CHANGED(chg), .OP_ERR(err));
	aba_host aba_host_inst (.CLK(clk), .SRST(srst), .LNK(lnk.host), .USR_START(start), .USR_OP(op),
		.USR_RAW_CMD(raw), .USR_ADDR(addr), .USR_MASK(mask), .USR_WDATA(wd), .USR_IMM(imm),
		.USR_BUSY(h_busy), .USR_DONE(h_done), .USR_RDATA(rdata), .USR_FLAG(h_flag), .USR_ERR(h_err));
	aba_props aba_props_inst (.CLK(clk), .SRST(srst), .req_valid(lnk.req_valid), .req_ready(lnk.req_ready),
		.req_cmd(lnk.req_cmd), .req_len(lnk.req_len), .req_addr(lnk.req_addr), .req_payload(lnk.req_payload),
		.rsp_valid(lnk.rsp_valid), .rsp_ready(lnk.rsp_ready), .rsp_payload(lnk.rsp_payload),
		.atomic_result_flag(lnk.atomic_result_flag), .rsp_err(lnk.rsp_err));
	// ---
	// helpers
	// ---
	task close_out;
		if (mismatches == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [127:0] got, input logic [127:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic aba_data_t rnd();
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
	endfunction
	// {err, flag, new block, answer}
	function automatic logic [257:0] calc(input aba_op_e o, input logic a3, input aba_half_t m, w,
		input aba_data_t im, od);
		aba_half_t h, nh;
		h = a3 ? od[127:64] : od[63:0];
		nh = (h & ~m) | (w & m);
		case (o)
			ABA_OP_MASKED_WRITE: calc = {1'b0, |(h ^ nh), a3 ? {nh, od[63:0]} : {od[127:64], nh},
				`ABA_ZERO_HALF, h};
			ABA_OP_EXCHANGE: calc = {2'b00, im, od};
			ABA_OP_AND: calc = {1'b0, |(od & ~im), od & im, od};
			default: calc = {2'b10, od, `ABA_ZERO_DATA};
		endcase
	endfunction
	task op_run(input aba_op_e o, input logic [15:0] a, input aba_half_t m, w, input aba_data_t im);
		logic [257:0] e;
		e = calc(o, a[3], m, w, im, mem[a[7:4]]);
		raw = 7'($random(seed));
		if (raw inside {`ABA_CMD_MASKED_WRITE_RETURN, `ABA_CMD_EXCHANGE_SIXTEEN, `ABA_CMD_AND_SIXTEEN})
			raw = 7'h00;
		op = o;
		addr = a;
		mask = m;
		wd = w;
		imm = im;
		start = 1;
		@(negedge clk);
		start = 0;
		for (n = 0; n < 20 && h_done !== 1'b1; n++)
			@(negedge clk);
		chk(128'({h_done, done, h_busy, busy}), 128'hc);
		chk(rdata, e[127:0]);
		chk(128'({h_err, h_flag}), 128'(e[257:256]));
		chk(128'({err, chg}), 128'(e[257:256]));
		mem[a[7:4]] = e[255:128];
	endtask
	task do_reset;
		srst = 1;
		for (i = 0; i < 16; i++)
			mem[i] = '0;
		repeat (3) @(negedge clk);
		srst = 0;
	endtask
	// ---
	// scenarios
	// ---
	initial begin
		do_reset();
		chk(128'({lnk.req_ready, busy, h_busy, lnk.rsp_valid}), 128'h8);
		op_run(ABA_OP_AND, 16'h0010, '0, '0, '0);
		op_run(ABA_OP_EXCHANGE, 16'h0014, '0, '0, rnd());
		op_run(ABA_OP_MASKED_WRITE, 16'h0018, '0, 64'(rnd()), '0);
		op_run(ABA_OP_MASKED_WRITE, 16'h0010, '1, 64'(rnd()), '0);
		op_run(ABA_OP_MASKED_WRITE, 16'h001f, 64'(rnd()), 64'(rnd()), '0);
		op_run(ABA_OP_AND, 16'h0010, '0, '0, rnd());
		op_run(ABA_OP_AND, 16'h0010, '0, '0, '0);
		op_run(ABA_OP_AND, 16'h0010, '0, '0, '0);
		op_run(ABA_OP_RAW, 16'h0020, '0, '0, rnd());
		for (int k = 0; k < 120; k++) begin
			if (k == 60) begin
				do_reset();
				chk(128'({lnk.req_ready, busy, h_busy, lnk.rsp_valid}), 128'h8);
			end
			op_run(aba_op_e'(2'($random(seed))), 16'($random(seed)), 64'(rnd()), 64'(rnd()), rnd());
		end
		close_out();
	end
	initial begin
		#2_000_000;
		mismatches++;
		close_out();
	end
endmodule
